// ===== src/radio_power_pkg.sv
package radio_power_pkg;

	// Clock rate and derived millisecond scale
	localparam int unsigned CLK_HZ        = 200_000_000;
	localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;

	// Sequencing times in milliseconds
	localparam int unsigned POR_HOLD_MS   = 110;
	localparam int unsigned HOST_WAIT_MS  = 150;
	localparam int unsigned DISCHARGE_MS  = 10;

	// Millisecond times convert to cycles by exact multiplication, with no rounding
	localparam int unsigned POR_HOLD_CYCLES  = POR_HOLD_MS * CYCLES_PER_MS;
	localparam int unsigned HOST_WAIT_CYCLES = (HOST_WAIT_MS * CYCLES_PER_MS * 1) + 0;
	localparam int unsigned DISCHARGE_CYCLES = DISCHARGE_MS * CYCLES_PER_MS;

	// Counter width covers the longest count
	localparam int unsigned CNT_W = 25;

	// Synchronised pin positions
	localparam int unsigned PIN_N      = 3;
	localparam int unsigned PIN_LAN    = 0;
	localparam int unsigned PIN_BT     = 1;
	localparam int unsigned PIN_SUPPLY = 2;

	// Reset values of the outputs
	localparam logic RST_REG_EN  = 1'b0;
	localparam logic RST_SECTION = 1'b1;

	// Sequencer states
	typedef enum logic [0:0]
	{
		ST_POR_WAIT = 1'b0,
		ST_RUN      = 1'b1
	} seq_state_e;

endpackage

// ===== src/pin_sync_if.sv
`timescale 1ns/10ps
interface pin_sync_if;
	logic [radio_power_pkg::PIN_N-1:0] raw;
	logic [radio_power_pkg::PIN_N-1:0] sync;

	modport syncer
	(
		input  raw,
		output sync
	);
	modport user
	(
		output raw,
		input  sync
	);
endinterface

// ===== src/pin_sync.sv
`timescale 1ns/10ps
module pin_sync
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	// Pin levels in, synchronised levels out
	pin_sync_if.syncer      pins
);

	// Two flip-flops per pin; only the second stage is read
	genvar gi;
	generate
		for (gi = 0; gi < radio_power_pkg::PIN_N; gi = gi + 1)
		begin : g_bit
			logic meta_reg;
			logic stable_reg;

			always_ff @(posedge clk_i)
			begin
				if (srst_i)
				begin
					meta_reg   <= 1'b0;
					stable_reg <= 1'b0;
				end
				else
				begin
					meta_reg   <= pins.raw[gi];
					stable_reg <= meta_reg;
				end
			end

			assign pins.sync[gi] = stable_reg;
		end
	endgenerate

endmodule

// ===== src/radio_power_enable_sequencer.sv
`timescale 1ns/10ps
// Operation
// - Regulators on whenever LAN enable or Bluetooth enable is high, once the power-on hold has ended.
// - Regulators off when both enables are low.
// - LAN section leaves reset while LAN enable is high and the power-on hold has ended.
// - LAN section held in reset whenever LAN enable is low.
// - Bluetooth held in reset when its enable is low and LAN is high.
// - FM section follows the Bluetooth reset; host enables Bluetooth for FM.
// - Power-on reset hold lasts at most 110 ms after supplies are good.
module radio_power_enable_sequencer
#(
	parameter int unsigned POR_HOLD_CYCLES  = radio_power_pkg::POR_HOLD_CYCLES,
	parameter int unsigned HOST_WAIT_CYCLES = radio_power_pkg::HOST_WAIT_CYCLES,
	parameter int unsigned DISCHARGE_CYCLES = radio_power_pkg::DISCHARGE_CYCLES
)
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic srst_i,
	// Host enable pins and supply monitor
	input  wire logic lan_power_enable_i,
	input  wire logic bluetooth_power_enable_i,
	input  wire logic supplies_good_i,
	// Regulator and section resets
	output logic      regulator_enable_o,
	output logic      lan_reset_o,
	output logic      bluetooth_reset_o,
	output logic      fm_reset_o,
	// Sequencing status
	output logic      por_active_o,
	output logic      host_access_ready_o,
	output logic      discharge_active_o
);

	localparam int unsigned W = radio_power_pkg::CNT_W;
	localparam logic [W-1:0] POR_LAST  = W'(POR_HOLD_CYCLES - 1);
	localparam logic [W-1:0] HOST_LAST = W'(HOST_WAIT_CYCLES - 1);
	localparam logic [W-1:0] DIS_LOAD  = W'(DISCHARGE_CYCLES);
	localparam logic [W-1:0] CNT_ONE   = W'(1);
	localparam logic [W-1:0] CNT_ZERO  = W'(0);
	localparam logic [W-1:0] POR_FULL  = W'(POR_HOLD_CYCLES);
	localparam logic [W-1:0] HOST_FULL = W'(HOST_WAIT_CYCLES);

	pin_sync_if pins ();

	radio_power_pkg::seq_state_e state_reg;
	radio_power_pkg::seq_state_e state_next;
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic [W-1:0] dis_cnt_reg;
	logic [W-1:0] dis_cnt_next;

	// Pin levels into the synchroniser
	assign pins.raw[radio_power_pkg::PIN_LAN]    = lan_power_enable_i;
	assign pins.raw[radio_power_pkg::PIN_BT]     = bluetooth_power_enable_i;
	assign pins.raw[radio_power_pkg::PIN_SUPPLY] = supplies_good_i;

	pin_sync u_sync
	(
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.pins   (pins)
	);

	// Synchronised levels and decode
	wire lan_s     = pins.sync[radio_power_pkg::PIN_LAN];
	wire bt_s      = pins.sync[radio_power_pkg::PIN_BT];
	wire supply_s  = pins.sync[radio_power_pkg::PIN_SUPPLY];
	wire running   = (state_reg == radio_power_pkg::ST_RUN);
	wire any_on    = lan_s | bt_s;
	wire reg_en_d  = running & any_on;
	wire lan_rst_d = ~running | ~lan_s;
	wire bt_rst_d  = ~running | ~bt_s;
	wire por_done  = (cnt_reg == POR_LAST);
	wire host_rdy  = running & (cnt_reg >= HOST_LAST);
	wire reg_fall  = regulator_enable_o & ~reg_en_d;

	// Power-on reset hold then run; supply loss restarts the hold
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			radio_power_pkg::ST_POR_WAIT:
			begin
				if (supply_s && por_done)
				begin
					state_next = radio_power_pkg::ST_RUN;
				end
			end
			radio_power_pkg::ST_RUN:
			begin
				if (!supply_s)
				begin
					state_next = radio_power_pkg::ST_POR_WAIT;
				end
			end
			default:
			begin
				state_next = radio_power_pkg::ST_POR_WAIT;
			end
		endcase
	end

	// Time since supplies good, saturating at the host wait
	assign cnt_next = !supply_s ? CNT_ZERO :
		(cnt_reg >= HOST_LAST) ? cnt_reg : cnt_reg + CNT_ONE;

	// Buck discharge window after the regulators drop
	assign dis_cnt_next = reg_fall ? DIS_LOAD :
		(dis_cnt_reg != CNT_ZERO) ? dis_cnt_reg - CNT_ONE : CNT_ZERO;

	// Sequencer state and counters
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			state_reg   <= radio_power_pkg::ST_POR_WAIT;
			cnt_reg     <= CNT_ZERO;
			dis_cnt_reg <= CNT_ZERO;
		end
		else
		begin
			state_reg   <= state_next;
			cnt_reg     <= cnt_next;
			dis_cnt_reg <= dis_cnt_next;
		end
	end

	// Registered outputs
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			regulator_enable_o  <= radio_power_pkg::RST_REG_EN;
			lan_reset_o         <= radio_power_pkg::RST_SECTION;
			bluetooth_reset_o   <= radio_power_pkg::RST_SECTION;
			fm_reset_o          <= radio_power_pkg::RST_SECTION;
			por_active_o        <= 1'b1;
			host_access_ready_o <= 1'b0;
			discharge_active_o  <= 1'b0;
		end
		else
		begin
			regulator_enable_o  <= reg_en_d;
			lan_reset_o         <= lan_rst_d;
			bluetooth_reset_o   <= bt_rst_d;
			fm_reset_o          <= bt_rst_d;
			por_active_o        <= ~running;
			host_access_ready_o <= host_rdy;
			discharge_active_o  <= (dis_cnt_next != CNT_ZERO);
		end
	end

	// Helper: cycles spent in the hold with supplies good
	logic [W-1:0] hold_cycles_reg;
	always_ff @(posedge clk_i)
	begin
		if (srst_i || running || !supply_s)
		begin
			hold_cycles_reg <= CNT_ZERO;
		end
		else
		begin
			hold_cycles_reg <= hold_cycles_reg + CNT_ONE;
		end
	end

	// Helper: cycles since supplies last turned good, saturating
	logic [W-1:0] good_cycles_reg;
	always_ff @(posedge clk_i)
	begin
		if (srst_i || !supply_s)
		begin
			good_cycles_reg <= CNT_ZERO;
		end
		else if (good_cycles_reg < HOST_FULL)
		begin
			good_cycles_reg <= good_cycles_reg + CNT_ONE;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	reg_on_a: assert property (running && any_on |=> regulator_enable_o)
		else $error("regulators not enabled with an enable high");
	reg_off_a: assert property (!lan_s && !bt_s |=> !regulator_enable_o)
		else $error("regulators enabled with both enables low");
	lan_release_a: assert property (running && lan_s |=> !lan_reset_o)
		else $error("lan section not released");
	lan_hold_a: assert property (!lan_s |=> lan_reset_o)
		else $error("lan section not held in reset");
	bt_hold_a: assert property (lan_s && !bt_s |=> bluetooth_reset_o)
		else $error("bluetooth section not held in reset");
	fm_follow_a: assert property (fm_reset_o == bluetooth_reset_o)
		else $error("fm reset differs from bluetooth reset");
	por_bound_a: assert property (!running |-> hold_cycles_reg < POR_FULL)
		else $error("power-on hold too long");
	host_ready_a: assert property ($rose(host_access_ready_o) |-> $past(running))
		else $error("host ready before power-on hold ended");
	discharge_win_a: assert property ($fell(regulator_enable_o) |-> discharge_active_o)
		else $error("discharge window not opened");
	por_hold_a: assert property (!running |=> lan_reset_o && bluetooth_reset_o
		&& !regulator_enable_o)
		else $error("section active during power-on hold");

	// Host-side timing aids, status flags, Bluetooth release and supply loss
	host_rise_a: assert property ($rose(host_access_ready_o) |-> $past(good_cycles_reg) >= HOST_LAST)
		else $error("host ready before the supply wait elapsed");
	host_keep_a: assert property (host_access_ready_o && running && supply_s |=> host_access_ready_o)
		else $error("host ready dropped while supplies stayed good");
	ready_off_a: assert property (!running |=> !host_access_ready_o)
		else $error("host ready during power-on hold");
	discharge_src_a: assert property ($rose(discharge_active_o) |-> $fell(regulator_enable_o))
		else $error("discharge window opened without a regulator drop");
	bt_release_a: assert property (running && bt_s |=> !bluetooth_reset_o)
		else $error("bluetooth section not released");
	supply_loss_a: assert property (!supply_s |-> ##2 !regulator_enable_o)
		else $error("regulators kept on after supply loss");
	por_flag_on_a: assert property (!running |=> por_active_o)
		else $error("power-on flag low during hold");
	por_flag_off_a: assert property (running |=> !por_active_o)
		else $error("power-on flag high after hold");

endmodule

// ===== tb/host_pins_model.sv
`timescale 1ns/10ps
module host_pins_model
#(
	parameter int unsigned GAP = 10
)
(
	// Clock and wanted levels
	input  wire logic clk_i,
	input  wire logic want_lan_i,
	input  wire logic want_bt_i,
	// Enable pins
	output logic      lan_o,
	output logic      bt_o
);
	logic [7:0] gap_reg = 8'h00;

	initial
	begin
		lan_o = 1'b0;
		bt_o = 1'b0;
	end
	// Counts how long both pins have been low
	always @(posedge clk_i)
	begin
		if (lan_o | bt_o)
			gap_reg <= 8'h00;
		else if (gap_reg < GAP)
			gap_reg <= gap_reg + 8'h01;
	end
	// Raise only after the buck has had time to discharge; later is harmless
	always @(posedge clk_i)
	begin
		if (lan_o | bt_o | (gap_reg >= GAP))
		begin
			lan_o <= want_lan_i;
			bt_o  <= want_bt_i;
		end
	end
endmodule

// ===== tb/test_radio_power_enable_sequencer.sv
`timescale 1ns/10ps
module test_radio_power_enable_sequencer;
	localparam int unsigned POR = 20;
	localparam int unsigned HW  = 40;
	localparam int unsigned DIS = 6;
	logic       clk_i     = 1'b0;
	logic       srst_i    = 1'b1;
	logic       want_lan  = 1'b0;
	logic       want_bt   = 1'b0;
	logic       sup       = 1'b0;
	logic       lan_pin;
	logic       bt_pin;
	logic [5:0] seen;
	logic [5:0] exp_q[$];
	logic       dis_seen;
	logic [7:0] dis_len   = 8'h00;
	logic [7:0] dis_q[$];
	logic       prev_on   = 1'b0;
	int         n_fail    = 0;
	int         cmp_count = 0;
	int         cyc       = 0;

	always #2.5 clk_i = ~clk_i;

	host_pins_model #(.GAP(DIS)) host (.clk_i(clk_i), .want_lan_i(want_lan),
		.want_bt_i(want_bt), .lan_o(lan_pin), .bt_o(bt_pin));

	radio_power_enable_sequencer #(.POR_HOLD_CYCLES(POR), .HOST_WAIT_CYCLES(HW),
		.DISCHARGE_CYCLES(DIS)) dut (.clk_i(clk_i), .srst_i(srst_i),
		.lan_power_enable_i(lan_pin), .bluetooth_power_enable_i(bt_pin),
		.supplies_good_i(sup), .regulator_enable_o(seen[5]), .lan_reset_o(seen[4]),
		.bluetooth_reset_o(seen[3]), .fm_reset_o(seen[2]), .por_active_o(seen[1]),
		.host_access_ready_o(seen[0]), .discharge_active_o(dis_seen));

	// Verdict and end of run
	task automatic complete_run();
		$display("Counts: %0d compared, %0d failed", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [5:0] e, input logic [5:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic cmp_len(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	// Ask for pin levels, let them settle, note the expected outputs
	task automatic step(input logic l, input logic b, input logic p, input logic r);
		logic on_now;
		on_now = !p & (l | b);
		want_lan <= l;
		want_bt <= b;
		// Every regulator drop opens one discharge window
		if (prev_on & !on_now)
			dis_q.push_back(8'(DIS));
		prev_on = on_now;
		repeat (DIS + 6) @(posedge clk_i);
		exp_q.push_back(p ? 6'b011110 : {l | b, !l, !b, !b, 1'b0, r});
	endtask

	// Takes the oldest note whenever outputs have settled
	always @(negedge clk_i)
	begin
		if (exp_q.size() > 0)
			cmp("outputs", exp_q.pop_front(), seen);
	end

	// Measures each discharge window and checks it against the oldest note
	always @(negedge clk_i)
	begin
		if (dis_seen === 1'b1)
			dis_len <= dis_len + 8'h01;
		else if (dis_len != 8'h00)
		begin
			cmp_len("discharge window", (dis_q.size() > 0) ? dis_q.pop_front() : 8'h00,
				dis_len);
			dis_len <= 8'h00;
		end
	end

	// Cuts a hang short
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_fail++;
			complete_run();
		end
	end

	initial
	begin
		void'($urandom(32'h6A9C));
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		sup <= 1'b1;
		step(1'b1, 1'b1, 1'b1, 1'b0);
		$display("Test hold done");
		step(1'b1, 1'b1, 1'b0, 1'b0);
		$display("Test hold end done");
		repeat (20) @(posedge clk_i);
		for (int k = 0; k < 4; k++)
			step(k[1], k[0], 1'b0, 1'b1);
		$display("Test combos done");
		repeat (8)
			step(1'($urandom), 1'($urandom), 1'b0, 1'b1);
		$display("Test random done");
		sup <= 1'b0;
		step(1'b1, 1'b0, 1'b1, 1'b0);
		$display("Test supply drop done");
		// Let the last note be compared before the verdict
		@(negedge clk_i);
		@(posedge clk_i);
		cmp_len("discharge notes left", 8'h00, 8'(dis_q.size()));
		complete_run();
	end
endmodule
